// ---- rtl/src_pkg.sv ----
package src_pkg;

   // ************************************************************
   // widths and timing
   // ************************************************************
   localparam int DATA_W        = 16;
   localparam int ADDR_W        = 4;
   localparam int NUM_SP        = 4;
   localparam int CLOCK_HZ      = 50_000_000;
   localparam int TICK_PERIOD_S = 1;
   localparam int TICK_CYCLES   = CLOCK_HZ * TICK_PERIOD_S;
   localparam int DIV_W         = 26;
   localparam int DLY_W         = 14;

   // ************************************************************
   // display span and reset values
   // ************************************************************
   localparam logic signed [DATA_W-1:0] SPAN_MIN  = 16'hF831;
   localparam logic signed [DATA_W-1:0] SPAN_MAX  = 16'h270F;
   localparam logic [DLY_W-1:0]         DELAY_MAX = 14'h270F;
   localparam logic signed [DATA_W-1:0] SP_RST    = 16'h0000;
   localparam logic [DLY_W-1:0]         DELAY_RST = 14'h0000;
   localparam logic                     BAND_HYSTERESIS_SELECT_RST  = 1'b0;
   localparam logic [1:0]               PAT_RST   = 2'h0;

   // ************************************************************
   // register offsets and fields
   // ************************************************************
   localparam logic [ADDR_W-1:0] OFS_SP1    = 4'h0;
   localparam logic [ADDR_W-1:0] OFS_SP2    = 4'h1;
   localparam logic [ADDR_W-1:0] OFS_SP3    = 4'h2;
   localparam logic [ADDR_W-1:0] OFS_SP4    = 4'h3;
   localparam logic [ADDR_W-1:0] OFS_MAKE   = 4'h4;
   localparam logic [ADDR_W-1:0] OFS_BREAK  = 4'h5;
   localparam logic [ADDR_W-1:0] OFS_CTRL   = 4'h6;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h7;
   localparam logic [ADDR_W-1:0] OFS_EVENT  = 4'h8;
   localparam logic [ADDR_W-1:0] OFS_MASK   = 4'h9;
   localparam int CTRL_BAND_HYSTERESIS_SELECT  = 0;
   localparam int CTRL_PAT   = 1;
   localparam int ST_RELAY   = 0;
   localparam int ST_ALARM   = 4;
   localparam int ST_LOCK    = 8;
   localparam int ST_MENU    = 9;
   localparam int EVT_W      = 5;
   localparam int EVT_REJECT = 4;
   localparam logic [EVT_W-1:0] MASK_RST = 5'h00;

   // ************************************************************
   // menu states, gray along the button path except the M_PAT to M_RUN step
   // ************************************************************
   typedef enum logic [3:0] {
      M_RUN   = 4'h0,
      M_SP1   = 4'h1,
      M_MAKE  = 4'h3,
      M_BREAK = 4'h2,
      M_BAND_HYSTERESIS_SELECT  = 4'h6,
      M_SP2   = 4'h7,
      M_SP3   = 4'h5,
      M_SP4   = 4'h4,
      M_PAT   = 4'hC
   } src_menu_t;

   // pattern index to sense bits {sp4,sp3,sp2,sp1}, 1 = high-acting
   function automatic logic [NUM_SP-1:0] src_pat_vec(input logic [1:0] i);
      case (i)
         2'h0:    src_pat_vec = 4'h0;
         2'h1:    src_pat_vec = 4'hA;
         2'h2:    src_pat_vec = 4'hC;
         default: src_pat_vec = 4'hF;
      endcase
   endfunction : src_pat_vec

   function automatic logic signed [DATA_W-1:0] src_clamp(
      input logic signed [DATA_W-1:0] v);
      if (v < SPAN_MIN) src_clamp = SPAN_MIN;
      else if (v > SPAN_MAX) src_clamp = SPAN_MAX;
      else src_clamp = v;
   endfunction : src_clamp

endpackage : src_pkg

// ---- rtl/src_delay_if.sv ----
`timescale 1ns/1ps
interface src_delay_if;
   import src_pkg::*;
   logic             tick;
   logic             cond;
   logic [DLY_W-1:0] makeDelay;
   logic [DLY_W-1:0] breakDelay;
   logic             active;
   modport timer (input tick, cond, makeDelay, breakDelay, output active);
   modport ctrl  (output tick, cond, makeDelay, breakDelay, input active);
endinterface : src_delay_if

// ---- rtl/src_delay_timer.sv ----
`timescale 1ns/1ps
module src_delay_timer
   import src_pkg::*;
(
   // system
   input wire logic clock,
   input wire logic arst_n,
   // timer side
   src_delay_if.timer dly
);

   logic             actReg;
   logic             actNext;
   logic [DLY_W-1:0] cntReg;
   logic [DLY_W-1:0] cntNext;
   logic [DLY_W-1:0] dlyTarget;

   // first tick lands anywhere in the first second, so one extra tick
   // is counted to guarantee the whole programmed time
   always_comb begin
      actNext   = actReg;
      cntNext   = cntReg;
      dlyTarget = dly.cond ? dly.makeDelay : dly.breakDelay;
      if (dly.cond == actReg) begin
         cntNext = '0;
      end else if (dlyTarget == '0 || cntReg > dlyTarget) begin
         actNext = dly.cond;
         cntNext = '0;
      end else if (dly.tick) begin
         cntNext = cntReg + 14'h0001;
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         actReg <= 1'b0;
         cntReg <= DELAY_RST;
      end else begin
         actReg <= actNext;
         cntReg <= cntNext;
      end
   end

   assign dly.active = actReg;

   a_make_wait: assert property (@(posedge clock) disable iff (!arst_n)
      !actReg && dly.cond && dly.makeDelay != '0
      && cntReg <= dly.makeDelay |=> !actReg)
      else $error("make delay cut short");
   a_break_wait: assert property (@(posedge clock) disable iff (!arst_n)
      actReg && !dly.cond && dly.breakDelay != '0
      && cntReg <= dly.breakDelay |=> actReg)
      else $error("break delay cut short");
   a_timer_restart: assert property (@(posedge clock) disable iff (!arst_n)
      dly.cond == actReg |=> cntReg == '0)
      else $error("delay count not restarted");

endmodule : src_delay_timer

// ---- rtl/setpoint_relay_control.sv ----
`timescale 1ns/1ps
module setpoint_relay_control
   import src_pkg::*;
#(
   parameter int TICK_CYC = TICK_CYCLES
)(
   // system
   input  wire logic                     clock,
   input  wire logic                     arst_n,
   // converter result
   input  wire logic signed [DATA_W-1:0] reading,
   input  wire logic                     readingValid,
   // front and rear panel pins
   input  wire logic                     progBtn,
   input  wire logic                     upBtn,
   input  wire logic                     downBtn,
   input  wire logic                     lock_n,
   // register port
   input  wire logic [ADDR_W-1:0]        addr,
   input  wire logic [DATA_W-1:0]        wrData,
   input  wire logic                     wrStrobe,
   input  wire logic                     rdStrobe,
   output logic      [DATA_W-1:0]        rdData,
   // outputs
   output logic      [NUM_SP-1:0]        relay,
   output logic      [NUM_SP-1:0]        annunciator,
   output logic                          irq
);

   // ************************************************************
   // pin synchronisers, a level counts once stages 2 and 3 agree
   // ************************************************************
   logic [3:0] pinRaw;
   logic [3:0] s1Reg, s2Reg, s3Reg, lvlReg, lvlNext, lvlPrev;
   logic [3:0] rise;
   assign pinRaw = {lock_n, downBtn, upBtn, progBtn};

   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_pin
         always_comb begin
            lvlNext[g] = (s2Reg[g] == s3Reg[g]) ? s3Reg[g] : lvlReg[g];
         end
         assign rise[g] = lvlReg[g] & ~lvlPrev[g];
      end
   endgenerate

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         s1Reg   <= 4'h8;
         s2Reg   <= 4'h8;
         s3Reg   <= 4'h8;
         lvlReg  <= 4'h8;
         lvlPrev <= 4'h8;
      end else begin
         s1Reg   <= pinRaw;
         s2Reg   <= s1Reg;
         s3Reg   <= s2Reg;
         lvlReg  <= lvlNext;
         lvlPrev <= lvlReg;
      end
   end

   logic lockActive;
   logic progPress, upPress, downPress, combo;
   assign lockActive = ~lvlReg[3];
   assign combo      = lvlReg[0] & lvlReg[1] & (rise[0] | rise[1]);
   assign progPress  = rise[0] & ~lvlReg[1];
   assign upPress    = rise[1] & ~lvlReg[0];
   assign downPress  = rise[2];

   // ************************************************************
   // one-second tick divider
   // ************************************************************
   logic [DIV_W-1:0] divReg, divNext;
   logic             tick;
   assign tick = (divReg == DIV_W'(TICK_CYC - 1));

   always_comb begin
      divNext = tick ? '0 : divReg + 26'h0000001;
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) divReg <= '0;
      else divReg <= divNext;
   end

   // ************************************************************
   // menu and settings
   // ************************************************************
   src_menu_t                 stReg, stNext;
   logic signed [DATA_W-1:0]  spReg [NUM_SP];
   logic signed [DATA_W-1:0]  spNext [NUM_SP];
   logic [DLY_W-1:0]          makeReg, makeNext, breakReg, breakNext;
   logic                      hystReg, hystNext;
   logic [1:0]                patReg, patNext;
   logic [NUM_SP-1:0]         sense;
   logic                      reject;
   logic                      edit;
   logic signed [DATA_W-1:0]  step;
   int                        idx;

   assign sense = src_pat_vec(patReg);
   assign edit  = upPress | downPress;
   assign step  = upPress ? 16'sh0001 : -16'sh0001;

   always_comb begin
      stNext    = stReg;
      spNext    = spReg;
      makeNext  = makeReg;
      breakNext = breakReg;
      hystNext  = hystReg;
      patNext   = patReg;
      reject    = 1'b0;
      idx       = 0;
      case (stReg)
         M_RUN:   if (combo) stNext = M_SP1;
         M_SP1:   if (progPress) stNext = M_MAKE;
         M_MAKE:  if (progPress) stNext = M_BREAK;
         M_BREAK: if (progPress) stNext = M_BAND_HYSTERESIS_SELECT;
         M_BAND_HYSTERESIS_SELECT:  if (progPress) stNext = M_SP2;
         M_SP2:   if (progPress) stNext = M_SP3;
         M_SP3:   if (progPress) stNext = M_SP4;
         M_SP4:   if (progPress) stNext = M_PAT;
         M_PAT:   if (progPress) stNext = M_RUN;
         default: stNext = M_RUN;
      endcase
      if (edit && stReg != M_RUN) begin
         if (lockActive) begin
            reject = 1'b1;
         end else begin
            case (stReg)
               M_SP1, M_SP2, M_SP3, M_SP4: begin
                  idx = (stReg == M_SP1) ? 0 : (stReg == M_SP2) ? 1 :
                        (stReg == M_SP3) ? 2 : 3;
                  spNext[idx] = src_clamp(spReg[idx] + step);
               end
               M_MAKE:
                  if (upPress && makeReg < DELAY_MAX)
                     makeNext = makeReg + 14'h0001;
                  else if (downPress && makeReg != '0)
                     makeNext = makeReg - 14'h0001;
               M_BREAK:
                  if (upPress && breakReg < DELAY_MAX)
                     breakNext = breakReg + 14'h0001;
                  else if (downPress && breakReg != '0)
                     breakNext = breakReg - 14'h0001;
               M_BAND_HYSTERESIS_SELECT:  hystNext = ~hystReg;
               M_PAT:   patNext = upPress ? patReg + 2'h1 : patReg - 2'h1;
               default: reject = 1'b0;
            endcase
         end
      end
      // bus writes share the same lockout gate
      if (wrStrobe && addr <= OFS_CTRL) begin
         if (lockActive) begin
            reject = 1'b1;
         end else if (addr <= OFS_SP4) begin
            spNext[addr[1:0]] = src_clamp(wrData);
         end else if (addr == OFS_MAKE) begin
            makeNext = (wrData[DLY_W-1:0] > DELAY_MAX) ? DELAY_MAX
                                                       : wrData[DLY_W-1:0];
         end else if (addr == OFS_BREAK) begin
            breakNext = (wrData[DLY_W-1:0] > DELAY_MAX) ? DELAY_MAX
                                                        : wrData[DLY_W-1:0];
         end else begin
            hystNext = wrData[CTRL_BAND_HYSTERESIS_SELECT];
            patNext  = wrData[CTRL_PAT +: 2];
         end
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         stReg    <= M_RUN;
         spReg    <= '{default: SP_RST};
         makeReg  <= DELAY_RST;
         breakReg <= DELAY_RST;
         hystReg  <= BAND_HYSTERESIS_SELECT_RST;
         patReg   <= PAT_RST;
      end else begin
         stReg    <= stNext;
         spReg    <= spNext;
         makeReg  <= makeNext;
         breakReg <= breakNext;
         hystReg  <= hystNext;
         patReg   <= patNext;
      end
   end

   // ************************************************************
   // setpoint comparison, one pass per conversion
   // ************************************************************
   logic [NUM_SP-1:0] rawAlarm, alarmReg, alarmNext;
   logic              bandMode;
   assign bandMode = hystReg && (spReg[1] > spReg[0]);

   // unfitted relays still get evaluated and indicated
   generate
      for (g = 0; g < NUM_SP; g++) begin : g_cmp
         assign rawAlarm[g] = sense[g] ? (reading > spReg[g])
                                       : (reading < spReg[g]);
      end
   endgenerate

   always_comb begin
      alarmNext = alarmReg;
      if (readingValid) begin
         alarmNext = rawAlarm;
         if (bandMode) begin
            alarmNext[0] = alarmReg[0];
            if (!sense[0]) begin
               if (reading < spReg[0]) alarmNext[0] = 1'b1;
               else if (reading >= spReg[1]) alarmNext[0] = 1'b0;
            end else begin
               if (reading > spReg[1]) alarmNext[0] = 1'b1;
               else if (reading <= spReg[0]) alarmNext[0] = 1'b0;
            end
         end
      end
   end

   // ************************************************************
   // relays, first one through the delay timer
   // ************************************************************
   src_delay_if dly ();
   assign dly.tick       = tick;
   assign dly.cond       = alarmReg[0];
   assign dly.makeDelay  = makeReg;
   assign dly.breakDelay = breakReg;

   src_delay_timer u_timer (
      .clock  (clock),
      .arst_n (arst_n),
      .dly    (dly.timer)
   );

   logic [NUM_SP-1:0] relayReg, relayNext;
   always_comb begin
      relayNext = {alarmReg[3:1], dly.active};
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         alarmReg <= '0;
         relayReg <= '0;
      end else begin
         alarmReg <= alarmNext;
         relayReg <= relayNext;
      end
   end

   assign relay       = relayReg;
   assign annunciator = relayReg;

   // ************************************************************
   // events, mask and register reads
   // ************************************************************
   logic [EVT_W-1:0]  evtReg, evtNext, maskReg, maskNext, evtSet;
   logic [DATA_W-1:0] rdReg, rdNext;
   assign evtSet = {reject, relayNext ^ relayReg};

   always_comb begin
      evtNext  = evtReg;
      maskNext = maskReg;
      // set wins over a clear in the same cycle
      if (wrStrobe && addr == OFS_EVENT) evtNext = evtReg & ~wrData[EVT_W-1:0];
      if (wrStrobe && addr == OFS_MASK) maskNext = wrData[EVT_W-1:0];
      evtNext = evtNext | evtSet;
      rdNext  = '0;
      if (rdStrobe) begin
         if (addr <= OFS_SP4) rdNext = spReg[addr[1:0]];
         else if (addr == OFS_MAKE) rdNext = {2'h0, makeReg};
         else if (addr == OFS_BREAK) rdNext = {2'h0, breakReg};
         else if (addr == OFS_CTRL) rdNext = {13'h0000, patReg, hystReg};
         else if (addr == OFS_STATUS)
            rdNext = {3'h0, stReg, lockActive, alarmReg, relayReg};
         else if (addr == OFS_EVENT) rdNext = {11'h000, evtReg};
         else if (addr == OFS_MASK) rdNext = {11'h000, maskReg};
         else rdNext = '0;
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         evtReg  <= '0;
         maskReg <= MASK_RST;
         rdReg   <= '0;
      end else begin
         evtReg  <= evtNext;
         maskReg <= maskNext;
         rdReg   <= rdNext;
      end
   end

   assign rdData = rdReg;
   assign irq    = |(evtReg & maskReg);

   // ************************************************************
   // checks
   // ************************************************************
   a_high_compare: assert property (@(posedge clock) disable iff (!arst_n)
      readingValid && sense[3] && reading > spReg[3] |=> alarmReg[3])
      else $error("high setpoint missed");
   a_low_compare: assert property (@(posedge clock) disable iff (!arst_n)
      readingValid && !sense[2] && reading < spReg[2] |=> alarmReg[2])
      else $error("low setpoint missed");
   a_direct_relay: assert property (@(posedge clock) disable iff (!arst_n)
      ##1 relayReg[3:2] == $past(alarmReg[3:2]))
      else $error("relay 3 or 4 delayed");
   a_band_hold: assert property (@(posedge clock) disable iff (!arst_n)
      bandMode && !sense[0] && alarmReg[0] && readingValid
      && reading < spReg[1] |=> alarmReg[0])
      else $error("band dropped early");
   a_eval_once: assert property (@(posedge clock) disable iff (!arst_n)
      !readingValid |=> $stable(alarmReg))
      else $error("alarm moved without conversion");
   a_lock_blocks: assert property (@(posedge clock) disable iff (!arst_n)
      lockActive |=> $stable(spReg[0]) && $stable(makeReg) && $stable(hystReg))
      else $error("setting changed under lockout");
   a_menu_entry: assert property (@(posedge clock) disable iff (!arst_n)
      stReg == M_RUN && combo |=> stReg == M_SP1)
      else $error("menu not entered");
   a_band_hysteresis_select_toggle: assert property (@(posedge clock) disable iff (!arst_n)
      stReg == M_BAND_HYSTERESIS_SELECT && upPress && !lockActive && !wrStrobe
      |=> hystReg != $past(hystReg))
      else $error("hysteresis not toggled");
   a_led_relay: assert property (@(posedge clock) disable iff (!arst_n)
      annunciator == relay)
      else $error("annunciator differs from relay");
   a_span_limit: assert property (@(posedge clock) disable iff (!arst_n)
      spReg[0] >= SPAN_MIN && spReg[0] <= SPAN_MAX)
      else $error("setpoint out of span");

endmodule : setpoint_relay_control

// ---- tb/src_panel_model.sv ----
`timescale 1ns/1ps
// ********************
// operator panel, contacts and lamps
// ********************
module src_panel_model (
   // system
   input  wire logic       clock,
   // block outputs
   input  wire logic [3:0] relay,
   input  wire logic [3:0] annunciator,
   // panel pins
   output logic            progBtn,
   output logic            upBtn,
   output logic            downBtn,
   output logic            lock_n,
   // lamp faults seen
   output int              ledErrs
);
   initial begin
      progBtn = 1'b0;
      upBtn   = 1'b0;
      downBtn = 1'b0;
      lock_n  = 1'b1;
      ledErrs = 0;
   end
   // sampled mid-cycle, away from the register update
   always @(negedge clock) begin
      if (annunciator !== relay) begin
         ledErrs <= ledErrs + 1;
      end
   end
   // b is {down, up, prog}; held well past the synchroniser
   task automatic press(input logic [2:0] b);
      @(posedge clock);
      progBtn <= b[0];
      upBtn   <= b[1];
      downBtn <= b[2];
      repeat (8) @(posedge clock);
      progBtn <= 1'b0;
      upBtn   <= 1'b0;
      downBtn <= 1'b0;
      repeat (8) @(posedge clock);
   endtask : press
   task automatic setLock(input logic v);
      @(posedge clock);
      lock_n <= v;
      repeat (6) @(posedge clock);
   endtask : setLock
endmodule : src_panel_model

// ---- tb/setpoint_relay_control_tb.sv ----
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin \
   totalChecks++; \
   if ((got) !== (exp)) begin \
      errCount++; \
      $display("CHECK FAILED %s exp %0h got %0h", nm, exp, got); \
   end \
end
module setpoint_relay_control_tb;
   import src_pkg::*;
   logic                     clock;
   logic                     arst_n;
   logic signed [DATA_W-1:0] reading;
   logic                     readingValid;
   logic                     progBtn;
   logic                     upBtn;
   logic                     downBtn;
   logic                     lock_n;
   logic [ADDR_W-1:0]        addr;
   logic [DATA_W-1:0]        wrData;
   logic                     wrStrobe;
   logic                     rdStrobe;
   logic [DATA_W-1:0]        rdData;
   logic [NUM_SP-1:0]        relay;
   logic [NUM_SP-1:0]        annunciator;
   logic                     irq;
   logic [NUM_SP-1:0]        early;
   logic [NUM_SP-1:0]        e;
   logic [DATA_W-1:0]        q;
   int                       errCount;
   int                       totalChecks;
   int                       ledErrs;
   int                       n;
   int                       spv [4] = '{100, 200, 300, 400};
   int                       rv [3] = '{50, 250, 450};
   logic [3:0]               patSense [4] = '{4'h0, 4'hA, 4'hC, 4'hF};
   int                       bCtl [8] = '{3, 3, 3, 3, 7, 7, 7, 7};
   int                       bRd [8] = '{50, 150, 200, 150, 250, 150, 100, 150};
   logic [7:0]               bExp = 8'h33;
   logic [3:0]               mSt [8] = '{4'h1, 4'h3, 4'h2, 4'h6,
                                         4'h7, 4'h5, 4'h4, 4'hC};

   // short tick so delay runs stay a few dozen cycles
   setpoint_relay_control #(.TICK_CYC(10)) setpoint_relay_control_inst (
      .clock(clock), .arst_n(arst_n), .reading(reading),
      .readingValid(readingValid), .progBtn(progBtn), .upBtn(upBtn),
      .downBtn(downBtn), .lock_n(lock_n), .addr(addr), .wrData(wrData),
      .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData),
      .relay(relay), .annunciator(annunciator), .irq(irq));
   src_panel_model src_panel_model_inst (
      .clock(clock), .relay(relay), .annunciator(annunciator),
      .progBtn(progBtn), .upBtn(upBtn), .downBtn(downBtn),
      .lock_n(lock_n), .ledErrs(ledErrs));

   // ********************
   // bus and converter helpers
   // ********************
   // one strobe cycle, write when w is set, read otherwise
   task automatic busOp(input logic w, input int a, input int d);
      @(posedge clock);
      addr     <= 4'(a);
      wrData   <= 16'(d);
      wrStrobe <= w;
      rdStrobe <= ~w;
      @(posedge clock);
      wrStrobe <= 1'b0;
      rdStrobe <= 1'b0;
   endtask : busOp
   task automatic wr(input int a, input int d);
      busOp(1'b1, a, d);
   endtask : wr
   task automatic rdChk(input int a, input logic [15:0] m,
                        input logic [15:0] x);
      busOp(1'b0, a, 0);
      #1;
      q = rdData;
      `CHK("register", x, q & m)
   endtask : rdChk
   // returns once the delay-free first relay has had time to follow
   task automatic conv(input int r);
      @(posedge clock);
      reading      <= 16'(r);
      readingValid <= 1'b1;
      @(posedge clock);
      readingValid <= 1'b0;
      @(posedge clock);
      #1;
      early = relay;
      @(posedge clock);
      #1;
   endtask : conv
   task automatic settle();
      repeat (2) @(posedge clock);
      #1;
   endtask : settle
   function automatic logic [3:0] expRel(input int p, input int r);
      for (int i = 0; i < 4; i++) begin
         expRel[i] = patSense[p][i] ? (r > spv[i]) : (r < spv[i]);
      end
   endfunction : expRel
   task automatic wrapUp();
      $display("checks %0d errors %0d", totalChecks, errCount);
      if (errCount == 0 && totalChecks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : wrapUp

   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end
   initial begin
      #1_000_000;
      errCount++;
      wrapUp();
   end

   // ********************
   // scenarios
   // ********************
   initial begin
      arst_n = 1'b0;
      reading = 16'h0000;
      readingValid = 1'b0;
      addr = 4'h0;
      wrData = 16'h0000;
      wrStrobe = 1'b0;
      rdStrobe = 1'b0;
      errCount = 0;
      totalChecks = 0;
      repeat (3) @(posedge clock);
      arst_n <= 1'b1;
      for (int a = 0; a < 16; a++) rdChk(a, 16'hFFFF, 16'h0000);
      wr(OFS_SP1, 16'h7FFF);
      rdChk(OFS_SP1, 16'hFFFF, 16'h270F);
      wr(OFS_SP1, 16'h8000);
      rdChk(OFS_SP1, 16'hFFFF, 16'hF831);
      wr(OFS_MAKE, 16'hFFFF);
      rdChk(OFS_MAKE, 16'hFFFF, 16'h270F);
      wr(OFS_MAKE, 0);
      for (int i = 0; i < 4; i++) wr(i, spv[i]);
      for (int p = 0; p < 4; p++) begin
         wr(OFS_CTRL, p * 2);
         for (int k = 0; k < 3; k++) begin
            conv(rv[k]);
            e = expRel(p, rv[k]);
            `CHK("relay", e, relay)
            `CHK("fastRelay", e[3:2], early[3:2])
            `CHK("lamp", e, annunciator)
            rdChk(OFS_STATUS, 16'h00F0, {8'h00, e, 4'h0});
         end
      end
      wr(OFS_EVENT, 16'h001F);
      rdChk(OFS_EVENT, 16'hFFFF, 16'h0000);
      wr(OFS_MASK, 16'h0008);
      conv(50);
      rdChk(OFS_EVENT, 16'hFFFF, 16'h000F);
      `CHK("irq", 1'b1, irq)
      wr(OFS_MASK, 0);
      settle();
      `CHK("irq", 1'b0, irq)
      wr(OFS_MASK, 16'h0008);
      settle();
      `CHK("irq", 1'b1, irq)
      wr(OFS_EVENT, 16'h0008);
      settle();
      `CHK("irq", 1'b0, irq)
      rdChk(OFS_EVENT, 16'hFFFF, 16'h0007);
      for (int k = 0; k < 2; k++) begin
         for (int i = 0; i < 4; i++) wr(i, k ? 16'hF831 : 16'h270F);
         wr(OFS_CTRL, k ? 0 : 6);
         conv(k ? 16'hF831 : 16'h270F);
         `CHK("unusedSp", 4'h0, relay)
      end
      wr(OFS_SP1, 100);
      wr(OFS_SP2, 200);
      for (int i = 0; i < 8; i++) begin
         wr(OFS_CTRL, bCtl[i]);
         conv(bRd[i]);
         `CHK("band", bExp[i], relay[0])
      end
      wr(OFS_SP2, 50);
      wr(OFS_CTRL, 7);
      conv(75);
      `CHK("noBand", 1'b0, relay[0])
      wr(OFS_CTRL, 6);
      wr(OFS_MAKE, 2);
      wr(OFS_BREAK, 1);
      conv(50);
      conv(150);
      repeat (12) @(posedge clock);
      #1;
      `CHK("makeEarly", 1'b0, relay[0])
      conv(50);
      conv(150);
      for (n = 0; n < 40 && relay[0] !== 1'b1; n++) settle();
      `CHK("makeTime", 1'b1, n >= 10 && n <= 16)
      conv(50);
      for (n = 0; n < 30 && relay[0] !== 1'b0; n++) settle();
      `CHK("breakTime", 1'b1, n >= 5 && n <= 11)
      for (int i = 0; i < 8; i++) begin
         src_panel_model_inst.press(i == 0 ? 3'b011 : 3'b001);
         rdChk(OFS_STATUS, 16'h1E00, {3'b000, mSt[i], 9'h000});
         if (i == 3) begin
            src_panel_model_inst.press(3'b010);
            rdChk(OFS_CTRL, 16'h0001, 16'h0001);
            src_panel_model_inst.press(3'b100);
            rdChk(OFS_CTRL, 16'h0001, 16'h0000);
         end
      end
      src_panel_model_inst.setLock(1'b0);
      rdChk(OFS_STATUS, 16'h0100, 16'h0100);
      wr(OFS_EVENT, 16'h001F);
      src_panel_model_inst.press(3'b010);
      rdChk(OFS_CTRL, 16'h0007, 16'h0006);
      wr(OFS_SP1, 16'h01F4);
      rdChk(OFS_SP1, 16'hFFFF, 16'h0064);
      rdChk(OFS_EVENT, 16'h0010, 16'h0010);
      wr(OFS_MASK, 16'h0010);
      settle();
      `CHK("irqLock", 1'b1, irq)
      src_panel_model_inst.setLock(1'b1);
      src_panel_model_inst.press(3'b010);
      rdChk(OFS_CTRL, 16'h0006, 16'h0000);
      `CHK("lampFaults", 0, ledErrs)
      wrapUp();
   end
endmodule : setpoint_relay_control_tb
